//--- rtl/cgw_map.vh
// Register map, field positions, reset values and timing counts for the clock watchdog
`ifndef CGW_MAP_VH
`define CGW_MAP_VH

// ==========================================================
// Byte indices
`define CGW_IDX_TIMEOUT 8'h08
`define CGW_IDX_CONTROL 8'h09
`define CGW_IDX_RECOVERY 8'h0C

// ==========================================================
// Timeout config byte fields
`define CGW_TO_COUNT_HI 5
`define CGW_TO_COUNT_LO 1
`define CGW_TO_TICK_SEL 0
`define CGW_TO_RESET 8'h3E

// ==========================================================
// Control byte fields
`define CGW_CT_USB_DRV 7
`define CGW_CT_BUS_DRV 6
`define CGW_CT_MID_DRV 5
`define CGW_CT_RST_WD 4
`define CGW_CT_RST_FC 3
`define CGW_CT_FLAG 2
`define CGW_CT_RUN 1
`define CGW_CT_RESET 8'h00

// ==========================================================
// Recovery byte fields
`define CGW_RC_SRC 7
`define CGW_RC_RESET 8'h00

// ==========================================================
// Timing
`define CGW_CLK_PERIOD_NS 25
`define CGW_REF_PERIOD_NS 200
`define CGW_TICK_SHORT_MS 150
`define CGW_TICK_LONG_MS 2500
// Edges per millisecond first, so the long tick stays inside 32 bits
`define CGW_TICK_SHORT_EDGES (`CGW_TICK_SHORT_MS * (1000000 / `CGW_REF_PERIOD_NS))
`define CGW_TICK_LONG_EDGES (`CGW_TICK_LONG_MS * (1000000 / `CGW_REF_PERIOD_NS))
`define CGW_RST_PULSE_US 100
`define CGW_RST_PULSE_CYC ((`CGW_RST_PULSE_US * 1000) / `CGW_CLK_PERIOD_NS)

`endif

//--- rtl/cgw_ref_sync.v
// Reference clock synchroniser and rising edge finder
`timescale 1ns/100ps
module cgw_ref_sync (
    // Clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // Reference input
    input wire ref_clk_i,
    // Edge pulse
    output reg rise_o
);

reg sync_a;
reg sync_b;
reg sync_c;
reg stable;

// ==========================================================
// Three stages; a change is taken once the last two agree
always @(posedge clk_i) begin
    if (!rst_n_i) begin
        sync_a <= 1'b0;
        sync_b <= 1'b0;
        sync_c <= 1'b0;
        stable <= 1'b0;
        rise_o <= 1'b0;
    end else begin
        sync_a <= ref_clk_i;
        sync_b <= sync_a;
        sync_c <= sync_b;
        rise_o <= 1'b0;
        if (sync_b == sync_c && sync_c != stable) begin
            stable <= sync_c;
            rise_o <= sync_c;
        end
    end
end

endmodule // cgw_ref_sync

//--- rtl/cgw_watchdog.v
// Clock generator watchdog, reset control and drive strength bytes
//
// Contract
// RULE1: Five-bit timeout count scaled by tick prescaler
// RULE2: Tick select: 0 short tick, 1 long
// RULE3: Reaching zero sets flag; reset if enabled
// RULE4: Expiry reset pulse gated by enable bit
// RULE5: Frequency change reset pulse when enabled
// RULE6: Flag reads timeout; write one clears
// RULE7: Run bit low halts and reloads counter
// RULE8: Countdown starts only after frequency change
// RULE9: Expiry resets, switches recovery, locks mode
// RULE10: Locked mode ignores frequency change writes
// RULE11: Clearing run bit releases locked mode
// RULE12: USB clock drive boost bit
// RULE13: Bus clock drive boost bit
// RULE14: Mid clock drive boost bit
// RULE15: Recovery source: latched straps or programmed
// RULE16: One decrement per tick from reference edges
// RULE17: Each reset is one fixed-length pulse; a trigger during a pulse restarts the count, so the pulse runs longer
`timescale 1ns/100ps
`include "cgw_map.vh"
module cgw_watchdog #(
    parameter SHORT_TICK_EDGES = `CGW_TICK_SHORT_EDGES,
    parameter LONG_TICK_EDGES = `CGW_TICK_LONG_EDGES
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // Reference clock pin
    input wire ref_clk_i,
    // Control byte port from the serial bus engine
    input wire reg_wr_i,
    input wire [7:0] reg_idx_i,
    input wire [7:0] reg_wdata_i,
    output reg [7:0] reg_rdata_o,
    // Synthesizer events
    input wire freq_change_i,
    // Reset and recovery controls
    output reg sys_reset_o,
    output reg recovery_mode_o,
    output reg recovery_from_prog_o,
    output reg freq_write_lock_o,
    // Drive strength
    output reg usb_clock_drive_boost_o,
    output reg bus_clock_drive_boost_o,
    output reg mid_clock_drive_boost_o
);

// ==========================================================
// Storage
reg [4:0] watchdog_timeout_count;
reg watchdog_tick_select;
reg reset_on_expiry_enable;
reg reset_on_freq_change_enable;
reg expiry_flag;
reg watchdog_run;
reg recovery_source_select;
reg [4:0] count;
reg armed;
reg [23:0] tick_cnt;
reg [11:0] pulse_cnt;
wire ref_rise;
wire wr_timeout;
wire wr_control;
wire wr_recovery;
wire tick;
wire expire;
wire [23:0] tick_len;
wire fc_pulse;

// Cut to the counter widths on purpose
localparam integer PULSE_INT = `CGW_RST_PULSE_CYC;
localparam [11:0] PULSE_LEN = PULSE_INT[11:0];
localparam [7:0] TO_RESET_BYTE = `CGW_TO_RESET;
localparam [4:0] TO_RESET_COUNT = TO_RESET_BYTE[`CGW_TO_COUNT_HI:`CGW_TO_COUNT_LO];

// ==========================================================
// Write strobe decode, shared by all three bytes
function wr_hit;
    input wr;
    input [7:0] idx;
    input [7:0] want;
    begin
        wr_hit = wr && (idx == want);
    end
endfunction

assign wr_timeout = wr_hit(reg_wr_i, reg_idx_i, `CGW_IDX_TIMEOUT);
assign wr_control = wr_hit(reg_wr_i, reg_idx_i, `CGW_IDX_CONTROL);
assign wr_recovery = wr_hit(reg_wr_i, reg_idx_i, `CGW_IDX_RECOVERY);

// ==========================================================
// Reference edge source
cgw_ref_sync u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ref_clk_i(ref_clk_i),
    .rise_o(ref_rise)
);

// ==========================================================
// Register writes
always @(posedge clk_i) begin
    if (!rst_n_i) begin
        watchdog_timeout_count <= TO_RESET_COUNT;
        watchdog_tick_select <= 1'b0;
        reset_on_expiry_enable <= 1'b0;
        reset_on_freq_change_enable <= 1'b0;
        watchdog_run <= 1'b0;
        recovery_source_select <= 1'b0;
        usb_clock_drive_boost_o <= 1'b0;
        bus_clock_drive_boost_o <= 1'b0;
        mid_clock_drive_boost_o <= 1'b0;
    end else begin
        if (wr_timeout) begin
            watchdog_timeout_count <= reg_wdata_i[`CGW_TO_COUNT_HI:`CGW_TO_COUNT_LO]; // RULE1
            watchdog_tick_select <= reg_wdata_i[`CGW_TO_TICK_SEL]; // RULE2
        end
        if (wr_control) begin
            usb_clock_drive_boost_o <= reg_wdata_i[`CGW_CT_USB_DRV]; // RULE12
            bus_clock_drive_boost_o <= reg_wdata_i[`CGW_CT_BUS_DRV]; // RULE13
            mid_clock_drive_boost_o <= reg_wdata_i[`CGW_CT_MID_DRV]; // RULE14
            reset_on_expiry_enable <= reg_wdata_i[`CGW_CT_RST_WD]; // RULE4
            reset_on_freq_change_enable <= reg_wdata_i[`CGW_CT_RST_FC]; // RULE5
            watchdog_run <= reg_wdata_i[`CGW_CT_RUN];
        end
        if (wr_recovery) begin
            recovery_source_select <= reg_wdata_i[`CGW_RC_SRC]; // RULE15
        end
    end
end

// ==========================================================
// Prescaler; cleared while halted so the first tick is a full one
assign tick_len = watchdog_tick_select ? LONG_TICK_EDGES[23:0] : SHORT_TICK_EDGES[23:0]; // RULE2
assign tick = armed && ref_rise && (tick_cnt == tick_len - 24'h000001); // RULE16
assign expire = tick && count == 5'h00; // RULE3

always @(posedge clk_i) begin
    if (!rst_n_i) begin
        tick_cnt <= 24'h000000;
    end else if (!armed || tick) begin
        tick_cnt <= 24'h000000;
    end else if (ref_rise) begin
        tick_cnt <= tick_cnt + 24'h000001; // RULE16
    end
end

// ==========================================================
// Countdown, lock and flag
always @(posedge clk_i) begin
    if (!rst_n_i) begin
        count <= TO_RESET_COUNT;
        armed <= 1'b0;
        recovery_mode_o <= 1'b0;
        freq_write_lock_o <= 1'b0;
        recovery_from_prog_o <= 1'b0;
        expiry_flag <= 1'b0;
    end else begin
        if (!watchdog_run) begin
            count <= watchdog_timeout_count; // RULE7
            armed <= 1'b0; // RULE7
            recovery_mode_o <= 1'b0; // RULE11
            freq_write_lock_o <= 1'b0; // RULE11
        end else if (expire) begin
            // Count stays at zero until run is cleared
            armed <= 1'b0;
            recovery_mode_o <= 1'b1; // RULE9
            freq_write_lock_o <= 1'b1; // RULE10
            recovery_from_prog_o <= recovery_source_select; // RULE15
        end else begin
            if (freq_change_i && !recovery_mode_o) begin
                armed <= 1'b1; // RULE8
            end
            if (tick) begin
                count <= count - 5'h01; // RULE16
            end
        end
        // Set wins over a clear in the same cycle
        if (expire) begin
            expiry_flag <= 1'b1; // RULE3
        end else if (wr_control && reg_wdata_i[`CGW_CT_FLAG]) begin
            expiry_flag <= 1'b0; // RULE6
        end
    end
end

// ==========================================================
// Reset pulse; a new trigger during a pulse restarts it
assign fc_pulse = freq_change_i && reset_on_freq_change_enable; // RULE5

always @(posedge clk_i) begin
    if (!rst_n_i) begin
        pulse_cnt <= 12'h000;
        sys_reset_o <= 1'b0;
    end else if ((expire && reset_on_expiry_enable) || fc_pulse) begin
        pulse_cnt <= PULSE_LEN - 12'h001; // RULE17
        sys_reset_o <= 1'b1; // RULE4
    end else if (pulse_cnt != 12'h000) begin
        pulse_cnt <= pulse_cnt - 12'h001;
    end else begin
        sys_reset_o <= 1'b0; // RULE17
    end
end

// ==========================================================
// Read back, one cycle after the index
always @(posedge clk_i) begin
    if (!rst_n_i) begin
        reg_rdata_o <= 8'h00;
    end else begin
        case (reg_idx_i)
            `CGW_IDX_TIMEOUT: reg_rdata_o <= {2'h0, watchdog_timeout_count, watchdog_tick_select};
            `CGW_IDX_CONTROL: reg_rdata_o <= {usb_clock_drive_boost_o, bus_clock_drive_boost_o,
                mid_clock_drive_boost_o, reset_on_expiry_enable, reset_on_freq_change_enable,
                expiry_flag, watchdog_run, 1'b0}; // RULE6
            `CGW_IDX_RECOVERY: reg_rdata_o <= {recovery_source_select, 7'h00};
            default: reg_rdata_o <= 8'h00;
        endcase
    end
end

endmodule // cgw_watchdog

//--- tb/cgw_watchdog_asserts.sv
// Port checker for the clock watchdog
`timescale 1ns/100ps
module cgw_watchdog_asserts (
    // Clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // Inputs
    input wire reg_wr_i,
    input wire [7:0] reg_idx_i,
    input wire [7:0] reg_wdata_i,
    input wire freq_change_i,
    // Outputs
    input wire [7:0] reg_rdata_o,
    input wire sys_reset_o,
    input wire recovery_mode_o,
    input wire recovery_from_prog_o,
    input wire freq_write_lock_o,
    input wire usb_clock_drive_boost_o,
    input wire bus_clock_drive_boost_o,
    input wire mid_clock_drive_boost_o
);
    // ====
    // Shadows
    reg [7:0] ctl;
    reg src;
    reg [12:0] rcnt;
    wire wc = reg_wr_i && reg_idx_i == 8'h09;
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            ctl <= 8'h00;
            src <= 1'h0;
            rcnt <= 13'h0000;
        end else begin
            if (wc) ctl <= reg_wdata_i;
            if (reg_wr_i && reg_idx_i == 8'h0C) src <= reg_wdata_i[7];
            rcnt <= sys_reset_o ? rcnt + 13'h0001 : 13'h0000;
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // ====
    // Properties
    AST_LOCK: assert property (freq_write_lock_o == recovery_mode_o) else $error("lock mismatch");
    AST_FC_RST: assert property (freq_change_i && ctl[3] |=> sys_reset_o) else $error("no change reset");
    AST_PULSE: assert property ($fell(sys_reset_o) |-> rcnt == 13'h0FA0) else $error("pulse length");
    // Run bit lands one cycle after the write, the unlock one cycle later
    AST_UNLOCK: assert property (wc && !reg_wdata_i[1] |-> ##2 !recovery_mode_o)
        else $error("still locked");
    AST_NEED_RUN: assert property ($rose(recovery_mode_o) |-> $past(ctl[1]))
        else $error("expiry without run");
    AST_EXP_RST: assert property ($rose(recovery_mode_o) && $past(ctl[4]) |-> sys_reset_o)
        else $error("no reset");
    AST_RST_CAUSE: assert property ($rose(sys_reset_o) |->
        $past(freq_change_i) && $past(ctl[3]) || $rose(recovery_mode_o) && $past(ctl[4]))
        else $error("reset without cause");
    AST_DRV: assert property (wc |=>
        {usb_clock_drive_boost_o, bus_clock_drive_boost_o, mid_clock_drive_boost_o} == $past(reg_wdata_i[7:5]))
        else $error("drive bits");
    AST_SRC: assert property ($rose(recovery_mode_o) |-> recovery_from_prog_o == $past(src))
        else $error("source");
    AST_RSV: assert property ($past(reg_idx_i) == 8'h08 |-> reg_rdata_o[7:6] == 2'h0) else $error("rsv");
    C_EXP: cover property ($rose(recovery_mode_o));
    C_FC: cover property (freq_change_i && ctl[3]);
    C_UNL: cover property ($fell(recovery_mode_o));
endmodule // cgw_watchdog_asserts
bind cgw_watchdog cgw_watchdog_asserts i_cgw_watchdog_asserts (.clk_i, .rst_n_i, .reg_wr_i, .reg_idx_i,
    .reg_wdata_i, .freq_change_i, .reg_rdata_o, .sys_reset_o, .recovery_mode_o, .recovery_from_prog_o,
    .freq_write_lock_o, .usb_clock_drive_boost_o, .bus_clock_drive_boost_o, .mid_clock_drive_boost_o);

//--- tb/cgw_ref_source.sv
// Reference clock source model
`timescale 1ns/100ps
module cgw_ref_source (
    // Reference out
    output reg ref_clk_o
);
    // Free running, exactly eight system clock periods per reference period
    initial ref_clk_o = 1'b0;
    always #100 ref_clk_o = ~ref_clk_o;
endmodule // cgw_ref_source

//--- tb/cgw_watchdog_test.sv
// Self-checking bench for the clock watchdog
`timescale 1ns/100ps
module cgw_watchdog_test;
    // ====
    // Signals
    reg clk_i = 1'b0;
    reg rst_n_i = 1'b0;
    reg reg_wr_i = 1'b0;
    reg [7:0] reg_idx_i = 8'h00;
    reg [7:0] reg_wdata_i = 8'h00;
    reg freq_change_i = 1'b0;
    wire ref_clk_i, sys_reset_o, recovery_mode_o, recovery_from_prog_o, freq_write_lock_o;
    wire usb_clock_drive_boost_o, bus_clock_drive_boost_o, mid_clock_drive_boost_o;
    wire [7:0] reg_rdata_o;
    integer n_fail = 0;
    integer samples_checked = 0;
    integer n;
    always #12.5 clk_i = ~clk_i;
    cgw_ref_source i_cgw_ref_source (.ref_clk_o(ref_clk_i));
    // Short ticks keep the run brief
    cgw_watchdog #(.SHORT_TICK_EDGES(4), .LONG_TICK_EDGES(8)) i_cgw_watchdog (.clk_i, .rst_n_i, .ref_clk_i,
        .reg_wr_i, .reg_idx_i, .reg_wdata_i, .reg_rdata_o, .freq_change_i, .sys_reset_o, .recovery_mode_o,
        .recovery_from_prog_o, .freq_write_lock_o, .usb_clock_drive_boost_o, .bus_clock_drive_boost_o,
        .mid_clock_drive_boost_o);
    // ====
    // Tasks
    task complete_run;
        begin
            $display("checks %0d errors %0d", samples_checked, n_fail);
            if (n_fail == 0 && samples_checked > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    task chk(input [15:0] g, input [15:0] e);
        begin
            samples_checked = samples_checked + 1;
            if (g !== e) begin
                n_fail = n_fail + 1;
                $display("[ERR] %0t got %h want %h", $time, g, e);
            end
        end
    endtask
    task wr(input [7:0] i, input [7:0] d);
        begin
            @(posedge clk_i);
            reg_wr_i <= 1'b1;
            reg_idx_i <= i;
            reg_wdata_i <= d;
            @(posedge clk_i);
            reg_wr_i <= 1'b0;
        end
    endtask
    task rd(input [7:0] i, input [7:0] e);
        begin
            @(posedge clk_i);
            reg_idx_i <= i;
            repeat (2) @(posedge clk_i);
            #1 chk(reg_rdata_o, e);
        end
    endtask
    task fc;
        begin
            @(posedge clk_i);
            freq_change_i <= 1'b1;
            @(posedge clk_i);
            freq_change_i <= 1'b0;
        end
    endtask
    // Counts cycles while a signal holds, bounded
    task wt(input integer lim, input integer mode);
        begin
            #1 n = 0;
            while ((mode ? !recovery_mode_o : sys_reset_o) && n < lim) begin
                @(posedge clk_i);
                #1 n = n + 1;
            end
            if (n == lim) begin
                n_fail = n_fail + 1;
                $display("[ERR] %0t wait limit reached", $time);
                complete_run;
            end
        end
    endtask
    task t_regs;
        begin
            rd(8'h08, 8'h3E);
            rd(8'h09, 8'h00);
            wr(8'h07, 8'hFF);
            rd(8'h07, 8'h00);
            wr(8'h08, 8'hFF);
            rd(8'h08, 8'h3F);
            wr(8'h09, 8'hE1);
            rd(8'h09, 8'hE0);
            chk({usb_clock_drive_boost_o, bus_clock_drive_boost_o, mid_clock_drive_boost_o}, 7);
        end
    endtask
    task t_fc;
        begin
            wr(8'h09, 8'h08);
            fc;
            wt(5000, 0);
            chk(n[15:0], 4000);
            wr(8'h09, 8'h00);
            fc;
            wt(5000, 0);
            chk(n[15:0], 0);
        end
    endtask
    task t_expire(input sel, input [4:0] cnt, input re, input src);
        integer e;
        begin
            e = (cnt + 1) * (sel ? 8 : 4) * 8;
            wr(8'h0C, {src, 7'h00});
            wr(8'h08, {2'h0, cnt, sel});
            wr(8'h09, {3'h0, re, 4'h2});
            repeat (300) @(posedge clk_i);
            chk(recovery_mode_o, 0);
            fc;
            wt(e + 40, 1);
            chk(n >= e - 8 && n <= e + 16, 1);
            chk(sys_reset_o, re);
            chk(recovery_from_prog_o, src);
            rd(8'h09, {3'h0, re, 4'h6});
            fc;
            wr(8'h09, {3'h0, re, 4'h6});
            rd(8'h09, {3'h0, re, 4'h2});
            chk(freq_write_lock_o, 1);
            wr(8'h09, 8'h00);
            rd(8'h09, 8'h00);
            chk(recovery_mode_o, 0);
            wt(5000, 0);
        end
    endtask
    // ====
    // Sequence
    initial begin
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_regs;
        t_fc;
        // Zero count first: a missed reload then shows as an early expiry
        t_expire(1'b1, 5'h00, 1'b0, 1'b0);
        t_expire(1'b0, 5'h1F, 1'b1, 1'b1);
        complete_run;
    end
endmodule // cgw_watchdog_test
